// File: hdl/gcr_logic.v
// gauge control, reset and fault logic with a 16-bit serial frame
`timescale 1ns/10ps
`default_nettype none
`include "gcr_map.vh"
module gcr_logic (
   input  wire        clock_in,          // 25 MHz system clock
   input  wire        resetn_in,         // external reset, active low
   input  wire        logic_por_in,      // logic supply power-up pulse
   input  wire        motor_supply_low_in, // motor supply below 4.0 V
   input  wire        sclk_in,           // serial clock, sampled
   input  wire        csn_in,            // chip select, active low
   input  wire        sdi_in,            // serial data in
   output reg         sdo_out,           // serial data out
   output wire        sdo_oe_out,        // sdo drive enable
   input  wire [1:0]  overtemp_in,       // per-gauge hot level
   input  wire        undervolt_in,      // motor supply undervoltage
   input  wire        overvolt_in,       // motor supply overvoltage
   input  wire [1:0]  microstep_in,      // per-gauge microstep pulse
   input  wire [1:0]  at_target_in,      // pointer at commanded position
   input  wire [1:0]  undriven_coil_in,  // per-gauge undriven coil select
   input  wire [3:0]  coil_level_in,     // digitised coil levels g1c,g1s,g0c,g0s
   input  wire        zero_done_in,      // stall detected on active gauge
   input  wire [15:0] accumulator_in,    // zeroing accumulator
   output reg  [1:0]  coil_enable_out,   // per-gauge coil drive enable
   output reg         clock_max_sel_out, // calibrated clock as maximum
   output reg  [4:0]  cal_divisor_out,   // calibrated clock divisor
   output reg  [3:0]  full_step_time_out, // zeroing full-step time
   output reg         blanking_time_out, // zeroing blanking time
   output reg  [7:0]  preload_out,       // accumulator preload
   output reg         zero_location_out, // position-zero location
   output reg  [1:0]  zeroing_active_out, // per-gauge zeroing running
   output reg         zeroing_dir_out,   // zeroing direction
   output reg         zero_monitor_out,  // undriven coil on monitor pin
   output reg  [1:0]  cmd_accept_out     // gauge accepts other commands
);
   wire       rst_int_n = resetn_in & ~logic_por_in & ~motor_supply_low_in;
   reg        sclk_d_r;
   reg        csn_d_r;
   reg [15:0] shift_in_r;
   reg [15:0] shift_out_r;
   reg [4:0]  bit_cnt_r;
   reg [1:0]  ot_r;
   reg        uv_r;
   reg        ov_r;
   reg        cal_flag_r;
   reg [1:0]  moved_r;
   reg        cal_armed_r;
   reg        cal_run_r;
   reg [7:0]  pre_cnt_r;
   reg [4:0]  cal_cnt_r;
   reg [1:0]  view_r;
   reg        zero_gauge_r;
   wire sclk_rise = sclk_in & ~sclk_d_r;
   wire sclk_fall = ~sclk_in & sclk_d_r;
   wire cs_start  = ~csn_in & csn_d_r;
   wire cs_end    = csn_in & ~csn_d_r;
   wire frame_ok  = cs_end & (bit_cnt_r == `GCR_FRAME_BITS);
   wire [15:0] cmd = shift_in_r;
   wire [2:0]  op  = cmd[`GCR_CMD_HI:`GCR_CMD_LO];

   // accumulator nibble picked by the view select
   function [3:0] acc_view;
      input [15:0] acc;
      input [1:0]  sel;
      begin
         case (sel)
            2'h0:    acc_view = acc[3:0];
            2'h1:    acc_view = acc[7:4];
            2'h2:    acc_view = acc[11:8];
            default: acc_view = acc[15:12];
         endcase
      end
   endfunction

   // status fields; the reserved position always reads zero
   wire [3:0]  acc_nib = acc_view(accumulator_in, view_r);
   wire [15:0] status_word;
   reg  [15:0] cap_r;
   wire        enable_frame;
   wire        zcfg_frame;
   wire        zero_frame;
   wire        cal_out_of_range;
   wire [1:0]  mon_sel;

   assign status_word[`GCR_SO_ACC_HI:`GCR_SO_ACC_LO] = acc_nib;
   assign status_word[`GCR_SO_ST1:`GCR_SO_ST0]       = at_target_in;
   assign status_word[`GCR_SO_OV]                    = ov_r;
   assign status_word[`GCR_SO_RSV]                   = 1'b0;
   assign status_word[`GCR_SO_CAL]                   = cal_flag_r;
   assign status_word[`GCR_SO_UV]                    = uv_r;
   assign status_word[`GCR_SO_GAUGE1_MOVED_FLAG:`GCR_SO_GAUGE0_MOVED_FLAG]     = moved_r;
   assign status_word[`GCR_SO_Z1:`GCR_SO_Z0]         = zeroing_active_out;
   assign status_word[`GCR_SO_OT1:`GCR_SO_OT0]       = ot_r;

   // frame kinds, each true only in the cycle of the chip-select rise
   assign enable_frame = frame_ok & (op == `GCR_CMD_ENCAL) & ~cmd[`GCR_PE_NULL];
   assign zcfg_frame   = frame_ok & (op == `GCR_CMD_ZCFG);
   assign zero_frame   = frame_ok & (op == `GCR_CMD_ZERO);

   assign cal_out_of_range = (cal_cnt_r < `GCR_CAL_MIN) | (cal_cnt_r > `GCR_CAL_MAX);

   assign sdo_oe_out = ~csn_in;

   // serial frame shifter; status is captured at chip-select fall
   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         sclk_d_r    <= 1'b0;
         csn_d_r     <= 1'b1;
         shift_in_r  <= 16'h0000;
         shift_out_r <= 16'h0000;
         cap_r       <= 16'h0000;
         bit_cnt_r   <= 5'h00;
         sdo_out     <= 1'b0;
      end else begin
         sclk_d_r <= sclk_in;
         csn_d_r  <= csn_in;
         if (cs_start) begin
            shift_out_r <= status_word;
            cap_r       <= status_word;
            sdo_out     <= status_word[`GCR_FRAME_BITS-1];
            bit_cnt_r   <= 5'h00;
         end else if (!csn_in && sclk_rise) begin
            shift_in_r <= {shift_in_r[14:0], sdi_in};
            if (bit_cnt_r != `GCR_FRAME_BITS) begin
               bit_cnt_r <= bit_cnt_r + 5'h01;
            end
         end else if (!csn_in && sclk_fall) begin
            shift_out_r <= {shift_out_r[14:0], 1'b0};
            sdo_out     <= shift_out_r[14];
         end
      end
   end

   // fault latches: set wins over the clear made by a valid frame;
   // except for overtemperature, only a flag that went out in the captured word is cleared, so an
   // event arriving mid-frame survives to the next report
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gauge
         always @(posedge clock_in or negedge rst_int_n) begin
            if (!rst_int_n) begin
               ot_r[g] <= 1'b0;
            end else if (overtemp_in[g]) begin
               ot_r[g] <= 1'b1;
            end else if (enable_frame && cmd[`GCR_PE_EN0 + g]) begin
               // hot gauge keeps its flag until re-enabled once cool
               ot_r[g] <= 1'b0;
            end
         end

         always @(posedge clock_in or negedge rst_int_n) begin
            if (!rst_int_n) begin
               moved_r[g] <= 1'b0;
            end else if (microstep_in[g]) begin
               moved_r[g] <= 1'b1;
            end else if (frame_ok && cap_r[`GCR_SO_GAUGE0_MOVED_FLAG + g]) begin
               moved_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         uv_r <= 1'b1;
      end else if (undervolt_in) begin
         uv_r <= 1'b1;
      end else if (frame_ok && cap_r[`GCR_SO_UV]) begin
         uv_r <= 1'b0;
      end
   end

   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ov_r <= 1'b0;
      end else if (overvolt_in) begin
         ov_r <= 1'b1;
      end else if (frame_ok && cap_r[`GCR_SO_OV]) begin
         ov_r <= 1'b0;
      end
   end

   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cal_flag_r <= 1'b0;
      end else if (cs_end && cal_run_r && cal_out_of_range) begin
         cal_flag_r <= 1'b1;
      end else if (frame_ok && cap_r[`GCR_SO_CAL]) begin
         cal_flag_r <= 1'b0;
      end
   end

   // calibration: armed frame, then the next chip-select pulse is timed
   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cal_armed_r     <= 1'b0;
         cal_run_r       <= 1'b0;
         pre_cnt_r       <= 8'h00;
         cal_cnt_r       <= 5'h00;
         cal_divisor_out <= 5'h00;
      end else begin
         if (cs_start && cal_armed_r) begin
            cal_run_r   <= 1'b1;
            cal_armed_r <= 1'b0;
            pre_cnt_r   <= 8'h00;
            cal_cnt_r   <= 5'h00;
         end else if (cal_run_r && !csn_in) begin
            // saturate so a long pulse still reads as out of range
            if (pre_cnt_r == `GCR_CAL_PRESCALE - 1) begin
               pre_cnt_r <= 8'h00;
               if (cal_cnt_r != 5'h1f) begin
                  cal_cnt_r <= cal_cnt_r + 5'h01;
               end
            end else begin
               pre_cnt_r <= pre_cnt_r + 8'h01;
            end
         end else if (cal_run_r && cs_end) begin
            cal_run_r       <= 1'b0;
            cal_divisor_out <= cal_cnt_r;
         end else if (enable_frame) begin
            cal_armed_r <= cmd[`GCR_PE_CAL];
         end
      end
   end

   // coil enables: a hot gauge is forced off, a zeroing gauge ignores frames
   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         coil_enable_out <= 2'h0;
      end else begin
         if (overtemp_in[0]) begin
            coil_enable_out[0] <= 1'b0;
         end else if (enable_frame && !zeroing_active_out[0]) begin
            coil_enable_out[0] <= cmd[`GCR_PE_EN0];
         end
         if (overtemp_in[1]) begin
            coil_enable_out[1] <= 1'b0;
         end else if (enable_frame && !zeroing_active_out[1]) begin
            coil_enable_out[1] <= cmd[`GCR_PE_EN1];
         end
      end
   end

   // enable frame settings
   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         clock_max_sel_out <= 1'b0;
         zero_location_out <= 1'b0;
         view_r            <= 2'h0;
      end else if (enable_frame) begin
         clock_max_sel_out <= cmd[`GCR_PE_CLKSEL];
         zero_location_out <= cmd[`GCR_PE_ZLOC];
         view_r            <= cmd[`GCR_PE_VIEW_HI:`GCR_PE_VIEW_LO];
      end
   end

   // zeroing configuration; full-step time has its own reset value
   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         full_step_time_out <= `GCR_FST_RESET;
         blanking_time_out  <= 1'b0;
         preload_out        <= 8'h00;
      end else if (zcfg_frame) begin
         full_step_time_out <= cmd[`GCR_RC_FST_HI:`GCR_RC_FST_LO];
         blanking_time_out  <= cmd[`GCR_RC_BLANK];
         preload_out        <= {cmd[`GCR_RC_PLH_HI:`GCR_RC_PLH_LO],
                                cmd[`GCR_RC_PLL_HI:`GCR_RC_PLL_LO]};
      end
   end

   // zeroing events: one gauge at a time, a start is ignored while any
   // gauge is zeroing; a stall report ends the running event
   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         zeroing_active_out <= 2'h0;
         zeroing_dir_out    <= 1'b0;
         zero_gauge_r       <= 1'b0;
      end else if (zero_frame && !cmd[`GCR_RZ_EN]
                   && zeroing_active_out[cmd[`GCR_RZ_SEL]]) begin
         zeroing_active_out <= 2'h0;
      end else if (zero_frame && cmd[`GCR_RZ_EN]
                   && zeroing_active_out == 2'h0) begin
         zeroing_active_out[cmd[`GCR_RZ_SEL]] <= 1'b1;
         zero_gauge_r       <= cmd[`GCR_RZ_SEL];
         zeroing_dir_out    <= cmd[`GCR_RZ_DIR] ^ zero_location_out;
      end else if (zero_done_in && zeroing_active_out != 2'h0) begin
         zeroing_active_out <= 2'h0;
      end
   end

   // monitor index: gauge of the running event, then its undriven coil
   assign mon_sel = {zero_gauge_r, undriven_coil_in[zero_gauge_r]};

   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cmd_accept_out <= 2'h3;
      end else begin
         cmd_accept_out <= ~zeroing_active_out;
      end
   end

   // monitor pin follows the undriven coil level of the zeroing gauge, low when no gauge is zeroing
   always @(posedge clock_in or negedge rst_int_n) begin
      if (!rst_int_n) begin
         zero_monitor_out <= 1'b0;
      end else if (zeroing_active_out != 2'h0) begin
         zero_monitor_out <= coil_level_in[mon_sel];
      end else begin
         zero_monitor_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: hdl/gcr_map.vh
// constants and field map of the gauge control, reset and fault logic
// Summary of operation
// - zeroing routes undriven coil voltage to monitor
// - internal reset at logic power-up or low supply
// - low reset input forces default state
// - reset clears config except full-step time
// - reset disables coils and sets undervoltage flag
// - external reset loses calibration, speed, zeroing setup
// - faults latch, clear after shifted out validly
// - overtemperature disables only affected gauge, flags it
// - overtemp flag holds until re-enable when cool
// - clock and motion continue down to 4.0 V
// - enable bits per gauge plus calibration arm
// - armed chip-select pulse length calibrates clock
// - one bit picks maximum or nominal clock
// - zeroing config: step time, blanking, preload fields
// - out-of-range calibration reported on serial out
// - moved flag set after microstep since last report
// - static flag shows pointer at commanded position
// - null command bit only returns status
// - zeroing command: gauge, enable, direction bits
// - two-bit field selects accumulator view on output
// - zeroing gauge ignores other commands until done
// - calibration count 4..15 accepted, else flagged
`ifndef GCR_MAP_VH
`define GCR_MAP_VH
`define GCR_FRAME_BITS     16
`define GCR_CNT_W          5
// command selector in bits 15:13
`define GCR_CMD_HI         15
`define GCR_CMD_LO         13
`define GCR_CMD_ENCAL      3'h0
`define GCR_CMD_ZCFG       3'h1
`define GCR_CMD_ZERO       3'h2
// enable / calibrate fields
`define GCR_PE_EN0         0
`define GCR_PE_EN1         1
`define GCR_PE_CAL         3
`define GCR_PE_CLKSEL      4
`define GCR_PE_ZLOC        7
`define GCR_PE_VIEW_HI     11
`define GCR_PE_VIEW_LO     10
`define GCR_PE_NULL        12
// zeroing config fields
`define GCR_RC_FST_HI      3
`define GCR_RC_FST_LO      0
`define GCR_RC_BLANK       4
`define GCR_RC_PLL_HI      10
`define GCR_RC_PLL_LO      5
`define GCR_RC_PLH_HI      12
`define GCR_RC_PLH_LO      11
`define GCR_FST_RESET      4'h1
// zeroing command fields
`define GCR_RZ_SEL         0
`define GCR_RZ_EN          1
`define GCR_RZ_DIR         2
// status word positions
`define GCR_SO_OT0         0
`define GCR_SO_OT1         1
`define GCR_SO_Z0          2
`define GCR_SO_Z1          3
`define GCR_SO_GAUGE0_MOVED_FLAG        4
`define GCR_SO_GAUGE1_MOVED_FLAG        5
`define GCR_SO_UV          6
`define GCR_SO_CAL         7
`define GCR_SO_OV          9
`define GCR_SO_RSV         8
`define GCR_SO_ST0         10
`define GCR_SO_ST1         11
`define GCR_SO_ACC_HI      15
`define GCR_SO_ACC_LO      12
// calibration: 8.0 us pulse, internal clock 2.0 MHz, count limits
`define GCR_CLK_MHZ        25
`define GCR_CAL_PULSE_NS   8000
`define GCR_CAL_DIV_NS     500
`define GCR_CAL_MIN        5'h04
`define GCR_CAL_MAX        5'h0f
`define GCR_CAL_PRESCALE   ((`GCR_CAL_DIV_NS * `GCR_CLK_MHZ) / 1000)
`endif

// File: tb/gcr_logic_props.sv
// assertions on the ports of the gauge control, reset and fault logic
`timescale 1ns/10ps
`default_nettype none
module gcr_logic_props (
   input wire logic       clock_in,            // clock
   input wire logic       resetn_in,           // external reset
   input wire logic       logic_por_in,        // power-up reset
   input wire logic       motor_supply_low_in, // supply reset
   input wire logic       csn_in,              // chip select
   input wire logic       sdo_oe_out,          // sdo enable
   input wire logic [1:0] overtemp_in,         // hot gauges
   input wire logic       zero_done_in,        // stall seen
   input wire logic [3:0] coil_level_in,       // coil levels
   input wire logic [1:0] undriven_coil_in,    // coil select
   input wire logic [1:0] coil_enable_out,     // coil drive
   input wire logic [3:0] full_step_time_out,  // step time
   input wire logic       blanking_time_out,   // blanking
   input wire logic [7:0] preload_out,         // preload
   input wire logic [1:0] zeroing_active_out,  // zeroing
   input wire logic [1:0] cmd_accept_out,      // accepting
   input wire logic       zero_monitor_out     // monitor pin
);
   wire logic rst_ok = resetn_in & ~logic_por_in & ~motor_supply_low_in;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_ok);
   property p_oe; sdo_oe_out == !csn_in; endproperty
   a_oe: assert property (p_oe) else $error("sdo enable wrong");
   property p_rst;
      $rose(rst_ok) |-> coil_enable_out == 2'h0 && full_step_time_out == 4'h1
         && preload_out == 8'h00 && zeroing_active_out == 2'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_ot0; overtemp_in[0] |-> ##[1:2] !coil_enable_out[0]; endproperty
   a_ot0: assert property (p_ot0) else $error("gauge 0 hot but driven");
   property p_ot1; overtemp_in[1] |-> ##[1:2] !coil_enable_out[1]; endproperty
   a_ot1: assert property (p_ot1) else $error("gauge 1 hot but driven");
   property p_hold;
      !csn_in ##1 !csn_in |-> $stable(full_step_time_out) && $stable(preload_out)
         && $stable(blanking_time_out);
   endproperty
   a_hold: assert property (p_hold) else $error("config moved mid frame");
   property p_excl; zeroing_active_out != 2'h3; endproperty
   a_excl: assert property (p_excl) else $error("both gauges zeroing");
   property p_acc; cmd_accept_out == ~$past(zeroing_active_out); endproperty
   a_acc: assert property (p_acc) else $error("accept wrong");
   property p_mon;
      zeroing_active_out[0] && $past(zeroing_active_out[0]) && $stable(coil_level_in)
         && $stable(undriven_coil_in) |-> zero_monitor_out ==
         coil_level_in[{1'b0, undriven_coil_in[0]}];
   endproperty
   a_mon: assert property (p_mon) else $error("monitor wrong");
   property p_done; zero_done_in && zeroing_active_out[0] |-> ##[1:3] !zeroing_active_out[0];
   endproperty
   a_done: assert property (p_done) else $error("zeroing not ended");
   c_zero: cover property (zeroing_active_out[0] ##1 !zeroing_active_out[0]);
   c_hot: cover property (overtemp_in[1] ##2 !coil_enable_out[1]);
   c_rst: cover property ($rose(rst_ok));
endmodule
bind gcr_logic gcr_logic_props i_gcr_logic_props (.clock_in, .resetn_in, .logic_por_in,
   .motor_supply_low_in, .csn_in, .sdo_oe_out, .overtemp_in, .zero_done_in, .coil_level_in,
   .undriven_coil_in, .coil_enable_out, .full_step_time_out, .blanking_time_out,
   .preload_out, .zeroing_active_out, .cmd_accept_out, .zero_monitor_out);
`default_nettype wire

// File: tb/gcr_spi_master.sv
// serial master model sending 16-bit frames and calibration pulses
`timescale 1ns/10ps
`default_nettype none
module gcr_spi_master (
   input  wire logic clock_in, // clock
   input  wire logic sdo_in,   // data from block
   output var  logic sclk_out, // serial clock, idle low
   output var  logic csn_out,  // chip select
   output var  logic sdi_out   // data to block
);
   initial begin
      sclk_out = 1'b0;
      csn_out = 1'b1;
      sdi_out = 1'b0;
   end
   task automatic pause(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   // nbits below 16 gives a frame the block must refuse
   task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] st);
      st = 16'h0000;
      csn_out = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         sdi_out = cmd[15-i];
         pause(3);
         st = {st[14:0], sdo_in};
         sclk_out = 1'b1;
         pause(3);
         sclk_out = 1'b0;
      end
      pause(3);
      csn_out = 1'b1;
      sdi_out = ~sdi_out; // no stale value once released
      pause(4);
   endtask
   task automatic cal_pulse(input int n);
      csn_out = 1'b0;
      pause(n);
      csn_out = 1'b1;
      pause(4);
   endtask
endmodule
`default_nettype wire

// File: tb/gcr_logic_tb.sv
// self-checking bench for the gauge control, reset and fault logic
`timescale 1ns/10ps
`default_nettype none
`include "gcr_map.vh"
module gcr_logic_tb;
   localparam logic [15:0] NUL = 16'h1000;
   logic clock_in, resetn_in, logic_por_in, motor_supply_low_in, zero_done_in;
   logic undervolt_in, overvolt_in;
   logic [1:0] overtemp_in, microstep_in, at_target_in, undriven_coil_in;
   logic [3:0] coil_level_in;
   logic [15:0] st, acc_in;
   wire logic sclk, csn, sdi, sdo, oe, cms, blk, zl, zd, zm;
   wire logic [1:0] ce, za, ca;
   wire logic [4:0] cd;
   wire logic [3:0] fst;
   wire logic [7:0] pl;
   int fails = 0, cmp_count = 0;
   gcr_logic i_gcr_logic (.clock_in, .resetn_in, .logic_por_in, .motor_supply_low_in,
      .sclk_in(sclk), .csn_in(csn), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(oe),
      .overtemp_in, .undervolt_in, .overvolt_in, .microstep_in, .at_target_in,
      .undriven_coil_in, .coil_level_in, .zero_done_in, .accumulator_in(acc_in),
      .coil_enable_out(ce), .clock_max_sel_out(cms), .cal_divisor_out(cd),
      .full_step_time_out(fst), .blanking_time_out(blk), .preload_out(pl),
      .zero_location_out(zl), .zeroing_active_out(za), .zeroing_dir_out(zd),
      .zero_monitor_out(zm), .cmd_accept_out(ca));
   gcr_spi_master i_gcr_spi_master (.clock_in, .sdo_in(sdo), .sclk_out(sclk),
      .csn_out(csn), .sdi_out(sdi));
   task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic frame(input logic [15:0] c);
      i_gcr_spi_master.xfer(c, 16, st);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_basic;
      check("fst", fst, `GCR_FST_RESET);
      frame(NUL);
      check("uv", st[`GCR_SO_UV], 1'b1);
      frame(16'h0013);
      check("uv", st[`GCR_SO_UV], 1'b0);
      check("ce", ce, 2'h3);
      check("cms", cms, 1'b1);
      frame(16'h0813);
      frame(NUL);
      check("ce", ce, 2'h3);
      check("acc", st[15:12], 4'ha);
      frame({3'h1, 2'h2, 6'h2a, 1'b1, 4'h9});
      check("fst", fst, 4'h9);
      check("pl", pl, 8'haa);
      check("blk", blk, 1'b1);
      i_gcr_spi_master.xfer(16'h2000, 8, st);
      check("fst", fst, 4'h9);
      $display("test basic done");
   endtask
   task automatic t_fault;
      overtemp_in = 2'h2;
      undervolt_in = 1'b1;
      overvolt_in = 1'b1;
      i_gcr_spi_master.pause(3);
      check("ce", ce, 2'h1);
      {overtemp_in, undervolt_in, overvolt_in} = 4'h0;
      frame(NUL);
      check("flags", {st[`GCR_SO_OV], st[`GCR_SO_UV], st[`GCR_SO_OT1]}, 3'h7);
      frame(NUL);
      check("flags", {st[`GCR_SO_OV], st[`GCR_SO_UV], st[`GCR_SO_OT1]}, 3'h1);
      frame(16'h0013);
      frame(NUL);
      check("ot1", st[`GCR_SO_OT1], 1'b0);
      check("ce", ce, 2'h3);
      $display("test fault done");
   endtask
   task automatic t_cal;
      int cyc[3] = '{25, 125, 250};
      for (int i = 0; i < 3; i++) begin
         frame(16'h001b);
         i_gcr_spi_master.cal_pulse(cyc[i]);
         frame(NUL);
         check("cal", st[`GCR_SO_CAL], i != 1);
         check("cd", cd, cyc[i] * 40 / 500);
         frame(NUL);
         check("cal", st[`GCR_SO_CAL], 1'b0);
      end
      $display("test cal done");
   endtask
   task automatic t_zero;
      at_target_in = 2'h3;
      acc_in = 16'h1234;
      microstep_in = 2'h1;
      i_gcr_spi_master.pause(1);
      microstep_in = 2'h0;
      frame(16'h0093);
      check("mov", st[5:4], 2'h1);
      check("stat", st[11:10], 2'h3);
      check("zl", zl, 1'b1);
      check("acc", st[15:12], 4'h4);
      at_target_in = 2'h2;
      frame(16'h4006);
      check("mov", st[5:4], 2'h0);
      check("stat", st[11:10], 2'h2);
      check("za", za, 2'h1);
      check("zd", zd, 1'b0);
      check("ca", ca, 2'h2);
      microstep_in = 2'h2;
      i_gcr_spi_master.pause(1);
      microstep_in = 2'h0;
      frame(16'h4003);
      check("mov", st[5:4], 2'h2);
      check("za", za, 2'h1);
      check("z0", st[`GCR_SO_Z0], 1'b1);
      frame(16'h0012);
      check("ce", ce, 2'h3);
      check("mon", zm, 1'b0);
      undriven_coil_in = 2'h1;
      coil_level_in = 4'h2;
      i_gcr_spi_master.pause(2);
      check("mon", zm, 1'b1);
      zero_done_in = 1'b1;
      i_gcr_spi_master.pause(1);
      zero_done_in = 1'b0;
      i_gcr_spi_master.pause(3);
      check("za", za, 2'h0);
      frame(16'h4003);
      check("za", za, 2'h2);
      frame(16'h4001);
      check("za", za, 2'h0);
      $display("test zero done");
   endtask
   task automatic t_reset;
      for (int i = 0; i < 3; i++) begin
         frame({3'h1, 2'h1, 6'h0f, 1'b0, 4'h7});
         resetn_in = (i != 0);
         logic_por_in = (i == 1);
         motor_supply_low_in = (i == 2);
         i_gcr_spi_master.pause(3);
         {resetn_in, logic_por_in, motor_supply_low_in} = 3'h4;
         i_gcr_spi_master.pause(2);
         check("fst", fst, `GCR_FST_RESET);
         check("pl", pl, 8'h00);
         check("ce", ce, 2'h0);
      end
      $display("test reset done");
   endtask
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   initial begin
      #800000;
      fails++;
      summarize;
   end
   initial begin
      {resetn_in, logic_por_in, motor_supply_low_in, zero_done_in} = 4'h0;
      {undervolt_in, overvolt_in, overtemp_in, microstep_in, at_target_in} = 8'h00;
      undriven_coil_in = 2'h2;
      coil_level_in = 4'h6;
      acc_in = 16'h5a3c;
      repeat (5) @(negedge clock_in);
      resetn_in = 1'b1;
      i_gcr_spi_master.pause(2);
      t_basic;
      t_fault;
      t_cal;
      t_zero;
      t_reset;
      summarize;
   end
endmodule
`default_nettype wire
